// File: sgirc_pkg.sv
// Constants, register map and types for the status, pin, interrupt and start-up controller
// Behaviour
// - Four multipurpose pins, each independently input or output.
// - Per pin, configuration picks register-controlled general purpose or fixed function.
// - Before configuration loads, every pin is an input acting as output-enable control; here clk_out_en stays 0 until then and only pins 1:0 ever select a map.
// - Fixed inputs: pin 2 picks reference 1 when high; pins 1:0 pick map.
// - Fixed outputs: pins 3..0 drive lock-loss, signal-loss 0, signal-loss 1, holdover.
// - A general-purpose input pin level is readable in the input register bit.
// - A general-purpose output pin drives the last written output register bit.
// - All status flags are active high.
// - Lock-loss clears on lock, or on lock with synchronisation finished, selectable.
// - Sticky interrupt flags for lock loss, holdover and both signal losses.
// - A flag stays set until alarm gone and software writes one, or reset.
// - Each flag has an enable gating the summary; enables clear on reset.
// - Summary flag and active-low interrupt pin assert when any enabled flag set.
// - Pins 1:0 as output-enable controls select one of four register-held maps.
// - Reset loads factory configuration; software writes are lost at reset.
// - Reset state while power-on reset or master reset input is asserted.
// - In reset, registers at defaults, state machines reset, bus accesses ignored.
// - In reset, pins are output-enable inputs, clocks disabled, interrupt bits cleared.
// - Self-configuration starts at the later release of both resets.
// - Load initial block first, then rest from serial memory, one-time memory, or both.
// - After full load, answer the bus, lock the PLL, then synchronise outputs.
// - Slave access to all registers; serial memory is only ever read.
// - Bus accesses wait while booting and are answered once configuration loads; changes possible once initialised.
package sgirc_pkg;
   localparam int NPINS = 4;
   localparam int NMAPS = 4;
   localparam int NOUTS = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_PIN_DIR = 8'h00;
   localparam logic [7:0] OFS_PIN_FUNC = 8'h04;
   localparam logic [7:0] OFS_PIN_OUT = 8'h08;
   localparam logic [7:0] OFS_PIN_IN = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STS = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN = 8'h14;
   localparam logic [7:0] OFS_OUTEN_MAP = 8'h18;
   localparam logic [7:0] OFS_CTRL = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam int ADDR_W = 8;

   // Field positions: flag vectors follow pin order 3..0
   localparam int FLG_HOLD = 0;
   localparam int FLG_LOS1 = 1;
   localparam int FLG_LOS0 = 2;
   localparam int FLG_LOL = 3;
   localparam int PIN_REFSEL = 2;
   localparam int CTRL_LOL_MODE = 0;
   localparam int CTRL_SW_REF = 1;
   localparam int ST_SUMMARY = 4;
   localparam int ST_CFG_DONE = 5;
   localparam int ST_RUNNING = 6;

   // Reset values
   localparam logic [3:0] RST_PIN_DIR = 4'h0;
   localparam logic [3:0] RST_PIN_FUNC = 4'h0;
   localparam logic [3:0] RST_PIN_OUT = 4'h0;
   localparam logic [3:0] RST_IRQ_EN = 4'h0;
   localparam logic [15:0] RST_OUTEN_MAP = 16'hFFFF;
   localparam logic [1:0] RST_CTRL = 2'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Configuration block codes on boot_blk
   localparam logic [1:0] BLK_OTP_INIT = 2'h0;
   localparam logic [1:0] BLK_EEPROM = 2'h1;
   localparam logic [1:0] BLK_OTP_REST = 2'h2;

   typedef enum logic [2:0] {
      BT_OTP_INIT,
      BT_CHECK,
      BT_EEPROM,
      BT_OTP_REST,
      BT_LOCK,
      BT_RUN
   } sgirc_boot_t;
endpackage

// File: sgirc_top.sv
// Multipurpose pins, status flags, sticky interrupts and start-up sequencer with AXI4-Lite registers
`timescale 1ns/1ps
module sgirc_top
   import sgirc_pkg::*;
(
   // Clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic master_reset_n,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Multipurpose pins
   input wire logic [NPINS-1:0] pin_i,
   output logic [NPINS-1:0] pin_o,
   output logic [NPINS-1:0] pin_oe,
   // PLL status
   input wire logic pll_locked,
   input wire logic pll_sync_busy,
   input wire logic [1:0] ref_los,
   input wire logic pll_holdover,
   // Configuration loader
   output logic boot_req,
   output logic [1:0] boot_blk,
   input wire logic boot_ack,
   input wire logic boot_use_eeprom,
   input wire logic boot_use_otp_rest,
   input wire logic [NPINS-1:0] otp_pin_dir,
   input wire logic [NPINS-1:0] otp_pin_func,
   input wire logic [15:0] otp_outen_map,
   // Clock control
   output logic [NOUTS-1:0] clk_out_en,
   output logic manual_ref_select,
   output logic pll_lock_start,
   output logic out_sync,
   // Interrupt pin
   output logic irq_n
);

   logic rst;
   logic [NPINS-1:0] pin_s1_q;
   logic [NPINS-1:0] pin_s2_q;
   logic [NPINS-1:0] pin_dir_q;
   logic [NPINS-1:0] pin_func_q;
   logic [NPINS-1:0] pin_out_reg_q;
   logic [NPINS-1:0] irq_en_q;
   logic [NPINS-1:0] irq_sts_q;
   logic [NPINS-1:0] irq_sts_d;
   logic [15:0] outen_map_q;
   logic [1:0] ctrl_q;
   logic [NPINS-1:0] flags_q;
   logic [NPINS-1:0] pin_o_q;
   logic [NPINS-1:0] pin_oe_q;
   logic [NOUTS-1:0] clk_out_en_q;
   logic ref_sel_q;
   logic irq_n_q;
   logic summary;
   sgirc_boot_t boot_q;
   logic boot_req_q;
   logic [1:0] boot_blk_q;
   logic lock_start_q;
   logic out_sync_q;
   logic cfg_done;
   logic [1:0] outen_sel;
   logic awready_q;
   logic wready_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_fire;
   logic [31:0] wmask;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;

   // Either reset source holds the whole block in its reset state
   assign rst = !aresetn || !master_reset_n;

   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   assign cfg_done = (boot_q == BT_LOCK) || (boot_q == BT_RUN);
   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign wmask = lane_mask(w_strb_q);

   // Pin synchronisers: stage one feeds only stage two
   generate
      for (genvar p = 0; p < NPINS; p++) begin : g_pin
         always_ff @(posedge aclk) begin
            if (rst) begin
               pin_s1_q[p] <= 1'b0;
               pin_s2_q[p] <= 1'b0;
            end else begin
               pin_s1_q[p] <= pin_i[p];
               pin_s2_q[p] <= pin_s1_q[p];
            end
         end

         always_ff @(posedge aclk) begin
            if (rst) begin
               pin_oe_q[p] <= 1'b0;
               pin_o_q[p] <= 1'b0;
            end else begin
               pin_oe_q[p] <= pin_dir_q[p];
               if (pin_func_q[p]) begin
                  pin_o_q[p] <= pin_out_reg_q[p];
               end else begin
                  pin_o_q[p] <= flags_q[p];
               end
            end
         end
      end
   endgenerate

   // Live status flags, active high
   always_ff @(posedge aclk) begin
      if (rst) begin
         flags_q <= 4'h0;
      end else begin
         // Mode 1 keeps lock-loss up until output synchronisation has settled
         flags_q[FLG_LOL] <= !pll_locked || (ctrl_q[CTRL_LOL_MODE] && pll_sync_busy);
         flags_q[FLG_LOS0] <= ref_los[0];
         flags_q[FLG_LOS1] <= ref_los[1];
         flags_q[FLG_HOLD] <= pll_holdover;
      end
   end

   // Sticky flags: an active alarm re-sets in the same cycle, so a clear only lands once it has gone
   always_comb begin
      irq_sts_d = irq_sts_q | flags_q;
      if (wr_fire && aw_addr_q == OFS_IRQ_STS) begin
         irq_sts_d = (irq_sts_q & ~(w_data_q[NPINS-1:0] & wmask[NPINS-1:0])) | flags_q;
      end
   end

   assign summary = |(irq_sts_q & irq_en_q);

   always_ff @(posedge aclk) begin
      if (rst) begin
         irq_sts_q <= 4'h0;
         irq_n_q <= 1'b1;
      end else begin
         irq_sts_q <= irq_sts_d;
         irq_n_q <= !(|(irq_sts_d & irq_en_q));
      end
   end

   // Pins 1:0 steer the map only when both are fixed-function inputs; otherwise map 0
   always_comb begin
      outen_sel = 2'h0;
      if (!pin_dir_q[1] && !pin_func_q[1] && !pin_dir_q[0] && !pin_func_q[0]) begin
         outen_sel = pin_s2_q[1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         clk_out_en_q <= 4'h0;
         ref_sel_q <= 1'b0;
      end else begin
         clk_out_en_q <= cfg_done ? outen_map_q[outen_sel*NOUTS +: NOUTS] : 4'h0;
         if (!pin_dir_q[PIN_REFSEL] && !pin_func_q[PIN_REFSEL]) begin
            ref_sel_q <= pin_s2_q[PIN_REFSEL];
         end else begin
            ref_sel_q <= ctrl_q[CTRL_SW_REF];
         end
      end
   end

   // Start-up sequencer
   always_ff @(posedge aclk) begin
      if (rst) begin
         boot_q <= BT_OTP_INIT;
         boot_req_q <= 1'b0;
         boot_blk_q <= BLK_OTP_INIT;
         lock_start_q <= 1'b0;
         out_sync_q <= 1'b0;
      end else begin
         out_sync_q <= 1'b0;
         case (boot_q)
            BT_OTP_INIT: begin
               boot_req_q <= !boot_ack;
               boot_blk_q <= BLK_OTP_INIT;
               if (boot_req_q && boot_ack) begin
                  boot_q <= BT_CHECK;
               end
            end
            BT_CHECK: begin
               if (boot_use_eeprom) begin
                  boot_q <= BT_EEPROM;
                  boot_blk_q <= BLK_EEPROM;
                  boot_req_q <= 1'b1;
               end else if (boot_use_otp_rest) begin
                  boot_q <= BT_OTP_REST;
                  boot_blk_q <= BLK_OTP_REST;
                  boot_req_q <= 1'b1;
               end else begin
                  boot_q <= BT_LOCK;
                  lock_start_q <= 1'b1;
               end
            end
            BT_EEPROM: begin
               if (boot_ack) begin
                  boot_req_q <= boot_use_otp_rest;
                  boot_blk_q <= BLK_OTP_REST;
                  boot_q <= boot_use_otp_rest ? BT_OTP_REST : BT_LOCK;
                  lock_start_q <= !boot_use_otp_rest;
               end
            end
            BT_OTP_REST: begin
               if (boot_ack) begin
                  boot_req_q <= 1'b0;
                  boot_q <= BT_LOCK;
                  lock_start_q <= 1'b1;
               end
            end
            BT_LOCK: begin
               if (pll_locked) begin
                  boot_q <= BT_RUN;
                  out_sync_q <= 1'b1;
               end
            end
            default: begin
               boot_q <= BT_RUN;
            end
         endcase
      end
   end

   // Configuration registers: factory load during boot, software writes only afterwards
   always_ff @(posedge aclk) begin
      if (rst) begin
         pin_dir_q <= RST_PIN_DIR;
         pin_func_q <= RST_PIN_FUNC;
         pin_out_reg_q <= RST_PIN_OUT;
         irq_en_q <= RST_IRQ_EN;
         outen_map_q <= RST_OUTEN_MAP;
         ctrl_q <= RST_CTRL;
      end else if (boot_q == BT_OTP_INIT && boot_req_q && boot_ack) begin
         pin_dir_q <= otp_pin_dir;
         pin_func_q <= otp_pin_func;
         outen_map_q <= otp_outen_map;
      end else if (wr_fire) begin
         if (aw_addr_q == OFS_PIN_DIR) begin
            pin_dir_q <= (pin_dir_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
         end else if (aw_addr_q == OFS_PIN_FUNC) begin
            pin_func_q <= (pin_func_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
         end else if (aw_addr_q == OFS_PIN_OUT) begin
            pin_out_reg_q <= (pin_out_reg_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
         end else if (aw_addr_q == OFS_IRQ_EN) begin
            irq_en_q <= (irq_en_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
         end else if (aw_addr_q == OFS_OUTEN_MAP) begin
            outen_map_q <= (outen_map_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
         end else if (aw_addr_q == OFS_CTRL) begin
            ctrl_q <= (ctrl_q & ~wmask[1:0]) | (w_data_q[1:0] & wmask[1:0]);
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      if (aw_addr_q == OFS_PIN_IN || aw_addr_q == OFS_STATUS) begin
         wr_hit = 1'b1;
      end else if (aw_addr_q > OFS_STATUS || aw_addr_q[1:0] != 2'h0) begin
         wr_hit = 1'b0;
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      if (s_axi_araddr == OFS_PIN_DIR) begin
         rd_word[3:0] = pin_dir_q;
      end else if (s_axi_araddr == OFS_PIN_FUNC) begin
         rd_word[3:0] = pin_func_q;
      end else if (s_axi_araddr == OFS_PIN_OUT) begin
         rd_word[3:0] = pin_out_reg_q;
      end else if (s_axi_araddr == OFS_PIN_IN) begin
         rd_word[3:0] = pin_s2_q;
      end else if (s_axi_araddr == OFS_IRQ_STS) begin
         rd_word[3:0] = irq_sts_q;
      end else if (s_axi_araddr == OFS_IRQ_EN) begin
         rd_word[3:0] = irq_en_q;
      end else if (s_axi_araddr == OFS_OUTEN_MAP) begin
         rd_word[15:0] = outen_map_q;
      end else if (s_axi_araddr == OFS_CTRL) begin
         rd_word[1:0] = ctrl_q;
      end else if (s_axi_araddr == OFS_STATUS) begin
         rd_word[3:0] = flags_q;
         rd_word[ST_SUMMARY] = summary;
         rd_word[ST_CFG_DONE] = cfg_done;
         rd_word[ST_RUNNING] = (boot_q == BT_RUN);
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Write channels; ready is withheld until configuration is loaded, so early accesses wait
   always_ff @(posedge aclk) begin
      if (rst) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         awready_q <= !awready_q && s_axi_awvalid && !aw_hold_q && !bvalid_q && cfg_done;
         wready_q <= !wready_q && s_axi_wvalid && !w_hold_q && !bvalid_q && cfg_done;
         if (s_axi_awvalid && awready_q) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel; address sampled at the handshake edge
   always_ff @(posedge aclk) begin
      if (rst) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else begin
         arready_q <= !arready_q && s_axi_arvalid && !rvalid_q && cfg_done;
         if (s_axi_arvalid && arready_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign pin_o = pin_o_q;
   assign pin_oe = pin_oe_q;
   assign clk_out_en = clk_out_en_q;
   assign manual_ref_select = ref_sel_q;
   assign irq_n = irq_n_q;
   assign boot_req = boot_req_q;
   assign boot_blk = boot_blk_q;
   assign pll_lock_start = lock_start_q;
   assign out_sync = out_sync_q;

endmodule

// File: sgirc_top_asserts.sv
// Port-level checker for the pin, interrupt and start-up controller
`timescale 1ns/1ps
module sgirc_top_chk
   import sgirc_pkg::*;
(
   // Clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic master_reset_n,
   // Bus handshakes
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_arready,
   input wire logic s_axi_bvalid,
   // Status and loader
   input wire logic pll_locked,
   input wire logic boot_req,
   input wire logic [1:0] boot_blk,
   input wire logic boot_ack,
   // Outputs
   input wire logic [NPINS-1:0] pin_oe,
   input wire logic [NOUTS-1:0] clk_out_en,
   input wire logic pll_lock_start,
   input wire logic out_sync,
   input wire logic irq_n
);
   wire rst = !aresetn || !master_reset_n;
   default clocking cb @(posedge aclk);
   endclocking
   a_reset_quiet: assert property (disable iff (rst)
      $rose(aresetn && master_reset_n) |-> irq_n && pin_oe == 4'h0 && clk_out_en == 4'h0)
      else $error("outputs busy right after reset");
   a_boot_start: assert property (disable iff (rst)
      $rose(aresetn && master_reset_n) |-> ##[1:2] boot_req && boot_blk == BLK_OTP_INIT)
      else $error("initial block not requested after reset");
   a_bus_closed: assert property (disable iff (rst)
      !pll_lock_start |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("bus taken before configuration loaded");
   a_lock_kept: assert property (disable iff (rst)
      pll_lock_start |=> pll_lock_start)
      else $error("lock start dropped");
   a_clocks_off: assert property (disable iff (rst)
      !pll_lock_start && !$past(pll_lock_start) |-> clk_out_en == 4'h0)
      else $error("clock outputs enabled before configuration");
   a_sync_pulse: assert property (disable iff (rst)
      out_sync |-> (pll_lock_start && $past(pll_locked)) ##1 !out_sync)
      else $error("output sync not a single pulse after lock");
   a_boot_held: assert property (disable iff (rst)
      boot_req && !boot_ack |=> boot_req && $stable(boot_blk))
      else $error("block request withdrawn unanswered");
   // Only a write can release the pin: a clear or an enable change
   a_irq_by_write: assert property (disable iff (rst)
      $rose(irq_n) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("interrupt released without a write");
endmodule
bind sgirc_top sgirc_top_chk chk_i (.*);

// File: sgirc_board.sv
// Behavioural configuration loader and factory image
`timescale 1ns/1ps
module sgirc_board
   import sgirc_pkg::*;
(
   // Clock and answer delay
   input wire logic aclk,
   input wire logic [3:0] dly,
   // Loader link
   input wire logic boot_req,
   output logic boot_ack,
   // Factory image
   output logic boot_use_eeprom,
   output logic boot_use_otp_rest,
   output logic [NPINS-1:0] otp_pin_dir,
   output logic [NPINS-1:0] otp_pin_func,
   output logic [15:0] otp_outen_map
);
   logic [3:0] cnt_q;
   // Both later sources used, so every loader step is walked
   assign boot_use_eeprom = 1'b1;
   assign boot_use_otp_rest = 1'b1;
   assign otp_pin_dir = 4'h0;
   assign otp_pin_func = 4'h0;
   assign otp_outen_map = 16'h8421;
   // Blocks are only read, never written back; dly makes the answer slow
   always_ff @(posedge aclk) begin
      if (!boot_req || boot_ack) begin
         cnt_q <= 4'h0;
         boot_ack <= 1'b0;
      end else if (cnt_q == dly) begin
         boot_ack <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

// File: status_gpio_irq_reset_ctrl_tb.sv
// Directed bench: bus tasks, board pins, status stimulus and expected values
`timescale 1ns/1ps
module status_gpio_irq_reset_ctrl_tb;
   import sgirc_pkg::*;
   logic aclk, aresetn, master_reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic pll_locked, pll_sync_busy, pll_holdover, boot_req, boot_ack, boot_use_eeprom, boot_use_otp_rest;
   logic manual_ref_select, pll_lock_start, out_sync, irq_n;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, ref_los, boot_blk, last_resp;
   logic [3:0] s_axi_wstrb, pin_i, pin_o, pin_oe, brd_q, clk_out_en, otp_pin_dir, otp_pin_func, dly;
   logic [15:0] otp_outen_map;
   int miscompares, checks;
   sgirc_top uut (.*);
   sgirc_board board (.*);
   // Pin level: the enabled side drives, otherwise the board's own level
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & brd_q);
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awready) aw_done = 1'b1;
         if (s_axi_wready) w_done = 1'b1;
         if (aw_done) s_axi_awvalid <= 1'b0;
         if (w_done) s_axi_wvalid <= 1'b0;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      last_resp = s_axi_bresp;
      @(posedge aclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      last_resp = s_axi_rresp;
      chk(s_axi_rdata, e);
      @(posedge aclk);
   endtask
   task automatic boot_up();
      do @(posedge aclk); while (!pll_lock_start);
      pll_locked <= 1'b1;
      cyc(4);
   endtask
   task automatic close_out();
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      cyc(20000);
      miscompares++;
      close_out();
   end
   initial begin
      miscompares = 0;
      checks = 0;
      aresetn = 1'b0;
      master_reset_n = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {pll_locked, pll_sync_busy, pll_holdover, ref_los} = 5'h00;
      brd_q = 4'h0;
      dly = 4'h0;
      cyc(16);
      chk({irq_n, pin_oe, clk_out_en}, 32'h100);
      aresetn <= 1'b1;
      boot_up();
      rdc(OFS_PIN_DIR, 32'h0);
      rdc(OFS_OUTEN_MAP, 32'h8421);
      rdc(OFS_STATUS, 32'h60);
      chk(last_resp, RESP_OKAY);
      rdc(8'h3C, 32'h0);
      chk(last_resp, RESP_SLVERR);
      $display("defaults done");
      for (int k = 0; k < 4; k++) begin
         brd_q <= 4'(k);
         cyc(5);
         chk(clk_out_en, 32'h1 << k);
      end
      brd_q <= 4'h4;
      cyc(5);
      chk({manual_ref_select, clk_out_en}, 32'h11);
      $display("fixed inputs done");
      wr(OFS_PIN_FUNC, 32'hF);
      brd_q <= 4'hA;
      cyc(4);
      rdc(OFS_PIN_IN, 32'hA);
      chk({manual_ref_select, clk_out_en}, 32'h1);
      wr(OFS_PIN_OUT, 32'h5);
      wr(OFS_PIN_DIR, 32'h3);
      cyc(4);
      rdc(OFS_PIN_IN, 32'h9);
      wr(OFS_PIN_DIR, 32'hF);
      cyc(3);
      chk({pin_oe, pin_o}, 32'hF5);
      $display("general purpose done");
      wr(OFS_PIN_FUNC, 32'h0);
      for (int i = 0; i < 4; i++) begin
         pll_holdover <= (i == 0);
         ref_los <= {i == 1, i == 2};
         pll_locked <= (i != 3);
         cyc(4);
         chk(pin_o, 32'h1 << i);
      end
      {pll_holdover, ref_los, pll_locked} <= 4'h1;
      cyc(4);
      chk(irq_n, 1'b1);
      rdc(OFS_IRQ_STS, 32'hF);
      wr(OFS_IRQ_STS, 32'hF);
      rdc(OFS_IRQ_STS, 32'h0);
      $display("fixed outputs done");
      wr(OFS_IRQ_EN, 32'h4);
      ref_los <= 2'h1;
      cyc(4);
      chk(irq_n, 1'b0);
      wr(OFS_IRQ_STS, 32'h4);
      rdc(OFS_IRQ_STS, 32'h4);
      ref_los <= 2'h0;
      cyc(4);
      chk(irq_n, 1'b0);
      wr(OFS_IRQ_STS, 32'h4);
      cyc(2);
      chk(irq_n, 1'b1);
      wr(OFS_CTRL, 32'h1);
      pll_sync_busy <= 1'b1;
      pll_locked <= 1'b0;
      cyc(3);
      pll_locked <= 1'b1;
      cyc(4);
      chk(pin_o[3], 1'b1);
      pll_sync_busy <= 1'b0;
      cyc(4);
      chk(pin_o[3], 1'b0);
      // Mode 0 releases on lock alone; software reference select also rides along
      wr(OFS_CTRL, 32'h2);
      chk(last_resp, RESP_OKAY);
      pll_sync_busy <= 1'b1;
      cyc(4);
      chk({manual_ref_select, pin_o[3]}, 32'h2);
      pll_sync_busy <= 1'b0;
      wr(8'h3C, 32'h1);
      chk(last_resp, RESP_SLVERR);
      $display("interrupts done");
      ref_los <= 2'h1;
      cyc(4);
      master_reset_n <= 1'b0;
      cyc(3);
      chk({irq_n, pin_oe, clk_out_en}, 32'h100);
      master_reset_n <= 1'b1;
      ref_los <= 2'h0;
      pll_locked <= 1'b0;
      dly <= 4'h5;
      // Issued at once: it must stall until configuration has loaded, before the PLL locks
      rdc(OFS_PIN_DIR, 32'h0);
      boot_up();
      rdc(OFS_IRQ_EN, 32'h0);
      rdc(OFS_CTRL, 32'h0);
      $display("master reset done");
      close_out();
   end
endmodule
